// ### dv/host_parallel_register_port_tb_top.sv
// self-checking bench joining both ends of the register port
`timescale 1ns/1ps
module host_parallel_register_port_tb_top;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic sync_mode = 1'b0;
    logic dev_reset = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [7:0] req_addr = 8'h00;
    logic [7:0] req_wdata = 8'h00;
    logic [7:0] alarm = 8'h00;
    logic req_ready, done, irq, wr_stb, mode_seen;
    logic [7:0] rdata, wr_addr, wr_data;
    logic [7:0] addrs [4] = '{8'h00, 8'h5A, 8'hA5, 8'hFF};
    int num_errors = 0;
    int checks_done = 0;
    int stb_cnt = 0;
    int cyc = 0;

    hpp_if bus_if();
    hpp_dev hpp_dev_inst (.ref_clk_i(ref_clk), .resetn_i(resetn), .bus(bus_if), .alarm_i(alarm),
        .wr_stb_o(wr_stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .sync_mode_o(mode_seen));
    hpp_host hpp_host_inst (.ref_clk_i(ref_clk), .resetn_i(resetn), .bus(bus_if), .sync_mode_i(sync_mode),
        .dev_reset_i(dev_reset), .req_valid_i(req_valid), .req_write_i(req_write), .req_addr_i(req_addr),
        .req_wdata_i(req_wdata), .req_ready_o(req_ready), .done_o(done), .rdata_o(rdata), .irq_o(irq));
    hpp_port_properties hpp_port_properties_inst (.ref_clk_i(ref_clk), .resetn_i(resetn),
        .bus_timing_select(bus_if.bus_timing_select), .dev_reset_n(bus_if.dev_reset_n),
        .chip_select_n(bus_if.chip_select_n), .read_strobe_n(bus_if.read_strobe_n),
        .store_strobe_n(bus_if.store_strobe_n), .addr(bus_if.addr), .d_dev_oe(bus_if.d_dev_oe),
        .d_host_oe(bus_if.d_host_oe),
        .ready_n(bus_if.ready_n), .alarm_irq_n(bus_if.alarm_irq_n));

    always #2.5 ref_clk = ~ref_clk;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up;
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    // a whole command on the user side, entered 1 ns after an edge
    task automatic cmd(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        int n;
        logic tk;
        n = 0;
        req_write = wr;
        req_addr = a;
        req_wdata = wd;
        req_valid = 1'b1;
        do begin
            tk = req_ready;
            @(posedge ref_clk);
            #1;
            n++;
        end while (tk !== 1'b1 && n < 20);
        req_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check("done", {7'h00, done}, 8'h01);
    endtask : cmd

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (wr_stb === 1'b1) begin
            stb_cnt <= stb_cnt + 1;
        end
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        idle(3);
        resetn = 1'b1;
        for (int m = 0; m < 2; m++) begin
            sync_mode = m[0];
            idle(20);
            check("mode", {7'h00, mode_seen}, {7'h00, m[0]});
            // back-to-back writes, then read all back
            for (int i = 0; i < 4; i++) begin
                cmd(1'b1, addrs[i], addrs[i] ^ 8'h33 ^ {m[0], 7'h00});
                check("wr_addr", wr_addr, addrs[i]);
                check("wr_data", wr_data, addrs[i] ^ 8'h33 ^ {m[0], 7'h00});
            end
            check("wr_count", 8'(stb_cnt), 8'(4 * (m + 1)));
            for (int i = 0; i < 4; i++) begin
                cmd(1'b0, addrs[i], 8'h00);
                check("rdata", rdata, addrs[i] ^ 8'h33 ^ {m[0], 7'h00});
            end
        end
        // status register refuses writes and clears on read
        cmd(1'b1, 8'h03, 8'h55);
        check("wr_count_status", 8'(stb_cnt), 8'h08);
        cmd(1'b0, 8'h03, 8'h00);
        check("status_idle", rdata, 8'h00);
        alarm = 8'h04;
        idle(30);
        check("irq_set", {7'h00, irq}, 8'h01);
        cmd(1'b0, 8'h03, 8'h00);
        check("status", rdata, 8'h04);
        idle(10);
        check("irq_clear", {7'h00, irq}, 8'h00);
        cmd(1'b0, 8'h03, 8'h00);
        check("status_clear", rdata, 8'h00);
        alarm = 8'h00;
        idle(30);
        check("irq_again", {7'h00, irq}, 8'h01);
        dev_reset = 1'b1;
        idle(20);
        dev_reset = 1'b0;
        idle(20);
        check("irq_reset", {7'h00, irq}, 8'h00);
        wrap_up();
    end
endmodule : host_parallel_register_port_tb_top

// ### dv/hpp_port_properties.sv
// checker for the pins between the two ends of the register port
`timescale 1ns/1ps
module hpp_port_properties (
    input wire logic ref_clk_i, // core clock
    input wire logic resetn_i, // async reset, active low
    input wire logic bus_timing_select, // high is sync timing
    input wire logic dev_reset_n, // device reset pin
    input wire logic chip_select_n, // select
    input wire logic read_strobe_n, // read strobe
    input wire logic store_strobe_n, // write strobe
    input wire logic [7:0] addr, // register address
    input wire logic d_dev_oe, // device drives data
    input wire logic d_host_oe, // host drives data
    input wire logic ready_n, // cycle finished
    input wire logic alarm_irq_n // alarm interrupt
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // cycles since the status register was last read or the device reset
    logic [7:0] since_clr_q;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            since_clr_q <= 8'hFF;
        end else if ((!chip_select_n && !read_strobe_n && addr == 8'h03) || !dev_reset_n) begin
            since_clr_q <= 8'h00;
        end else if (since_clr_q != 8'hFF) begin
            since_clr_q <= since_clr_q + 8'h01;
        end
    end

    chk_async_read_ready: assert property ($fell(read_strobe_n) && !chip_select_n && !bus_timing_select
        |-> ##[1:13] !ready_n) else $error("read ready late in async timing");
    chk_async_write_ready: assert property ($fell(store_strobe_n) && !chip_select_n && !bus_timing_select
        |-> ##[1:13] !ready_n) else $error("write ready late in async timing");
    // two bus clock periods of 50 ns plus 5 ns
    chk_sync_ready_bound: assert property (($fell(read_strobe_n) || $fell(store_strobe_n))
        && !chip_select_n && bus_timing_select |-> ##[1:21] !ready_n) else $error("ready late in sync timing");
    chk_ready_has_cause: assert property ($fell(ready_n)
        |-> !chip_select_n && !(read_strobe_n && store_strobe_n)) else $error("ready without a strobe");
    chk_ready_release: assert property ($rose(read_strobe_n) || $rose(store_strobe_n)
        |-> ##[1:6] ready_n) else $error("ready held after strobe release");
    chk_unselected_quiet: assert property (chip_select_n [*6] |-> ready_n && !d_dev_oe)
        else $error("activity while not selected");
    chk_bus_undriven: assert property ((read_strobe_n || chip_select_n) [*5] |-> !d_dev_oe)
        else $error("data driven outside a read");
    chk_read_drives: assert property ($fell(ready_n) && !read_strobe_n |-> d_dev_oe)
        else $error("read ready without data driven");
    chk_dev_reset_idle: assert property (!dev_reset_n [*6] |-> ready_n && !d_dev_oe && alarm_irq_n)
        else $error("device active in reset");
    chk_irq_read_clear: assert property ($rose(alarm_irq_n) |-> since_clr_q < 8'h28)
        else $error("interrupt released without status read");
    chk_addr_held: assert property (!chip_select_n && $past(!chip_select_n) |-> $stable(addr))
        else $error("address moved while selected");
    chk_read_after_select: assert property ($fell(read_strobe_n)
        |-> !chip_select_n && $past(!chip_select_n)) else $error("read strobe before select");
    chk_read_end_late: assert property ($rose(read_strobe_n) |-> !$past(ready_n))
        else $error("read ended before ready");
    chk_cs_gap: assert property ($rose(chip_select_n)
        |-> read_strobe_n && store_strobe_n ##1 chip_select_n) else $error("select not released between commands");
    chk_write_data_first: assert property ($fell(store_strobe_n)
        |-> !chip_select_n && d_host_oe && $past(d_host_oe)) else $error("write strobe before data");

    cov_async_read: cover property (!bus_timing_select && !read_strobe_n && $fell(ready_n));
    cov_sync_write: cover property (bus_timing_select && !store_strobe_n && $fell(ready_n));
    cov_irq_cycle: cover property ($rose(alarm_irq_n));
endmodule : hpp_port_properties

// ### hdl/hpp_cfg.svh
// constants of the host parallel register port
`ifndef HPP_CFG_SVH
`define HPP_CFG_SVH

// core clock period
`define HPP_CLK_NS 5

// strobe to ready, longest, per timing mode
`define HPP_RDY_ASYNC_NS 65
`define HPP_RDY_SYNC_NS 35
`define HPP_RDY_ASYNC_CYC (`HPP_RDY_ASYNC_NS / `HPP_CLK_NS)
`define HPP_RDY_SYNC_CYC (`HPP_RDY_SYNC_NS / `HPP_CLK_NS)
// synchronous mode: strobe to ready at most two bus clock periods plus this
`define HPP_RDY_SYNC_EXTRA_NS 5

// strobe pulse width, least, per timing mode
`define HPP_PW_ASYNC_NS 70
`define HPP_PW_SYNC_NS 40
`define HPP_PW_ASYNC_CYC ((`HPP_PW_ASYNC_NS + `HPP_CLK_NS - 1) / `HPP_CLK_NS)
`define HPP_PW_SYNC_CYC ((`HPP_PW_SYNC_NS + `HPP_CLK_NS - 1) / `HPP_CLK_NS)

// host bus clock: least period, and half period made by the host divider
`define HPP_PCLK_MIN_NS 15
`define HPP_PCLK_HALF_CYC 5
// idle cycles with chip select high between two commands
`define HPP_GAP_CYC 2

`define HPP_CNT_W 5
`define HPP_ALARM_ADDR 8'h03
`define HPP_ALARM_W 8
`define HPP_BUS_IDLE 8'hFF
`define HPP_DEV_SYNC_W 22
`define HPP_HOST_SYNC_W 10

`endif

// ### hdl/hpp_dev.sv
// device end of the host parallel register port
`timescale 1ns/1ps
`include "hpp_cfg.svh"
// Function
// - mode pin low async, high sync timing
// - eight-bit direct address selects one register
// - one eight-bit data bus, both directions
// - accesses only while chip select low
// - read starts on read strobe low
// - write starts on store strobe low
// - ready low marks cycle finished
// - alarm change raises irq, read clears
// - reset pin low resets device
// - sync mode times port by host clock
// - host: address valid before read strobe
// - drive data only during selected read
// - read data and ready within limit
// - host: raise read after ready seen
// - host: chip select high between commands
// - host: write data before store strobe
// - write commits, then ready within limit
// - sync ready within two periods plus 5ns
module hpp_dev (
    input wire logic ref_clk_i, // 200 MHz core clock
    input wire logic resetn_i, // async reset, active low
    hpp_if.dev bus, // pins from the local processor
    input wire logic [7:0] alarm_i, // alarm levels, core clock domain
    output logic wr_stb_o, // one-cycle pulse per committed write
    output logic [7:0] wr_addr_o, // address of the last write
    output logic [7:0] wr_data_o, // data of the last write
    output logic sync_mode_o // timing mode now in use, high is sync
);
    logic [`HPP_DEV_SYNC_W-1:0] pins;
    logic [`HPP_DEV_SYNC_W-1:0] pins_s;
    logic pclk_s;
    logic mode_s;
    logic rst_n_s;
    logic cs_n_s;
    logic rd_n_s;
    logic wr_n_s;
    logic [7:0] addr_s;
    logic [7:0] d_s;

    logic pclk_q;
    logic pclk_rise;
    logic tick;
    logic sel;
    logic rd_req;
    logic wr_req;
    logic accept;
    logic alarm_hit;

    hpp_pkg::hpp_dev_state_t state_q;
    logic [7:0] rdata_q;
    logic [7:0] mem_q [0:255];
    logic [`HPP_ALARM_W-1:0] alarm_q;
    logic [`HPP_ALARM_W-1:0] status_q;
    logic [`HPP_ALARM_W-1:0] status_d;
    logic irq_n_q;
    logic wr_stb_q;
    logic [7:0] wr_addr_q;
    logic [7:0] wr_data_q;

    // every pin, the bus clock too, is seen only through two flops
    // order must match the unpack below
    assign pins = {
        bus.host_bus_clock,
        bus.bus_timing_select,
        bus.dev_reset_n,
        bus.chip_select_n,
        bus.read_strobe_n,
        bus.store_strobe_n,
        bus.addr,
        bus.d
    };

    hpp_sync #(
        .W(`HPP_DEV_SYNC_W)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .d_i(pins),
        .q_o(pins_s)
    );

    assign {
        pclk_s,
        mode_s,
        rst_n_s,
        cs_n_s,
        rd_n_s,
        wr_n_s,
        addr_s,
        d_s
    } = pins_s;

    // bus clock edge finder
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pclk_q <= 1'b1;
        end else begin
            pclk_q <= pclk_s;
        end
    end

    assign pclk_rise = pclk_s & ~pclk_q;

    // async mode takes a command as soon as it is seen; sync mode only on a
    // bus clock rising edge, so ready follows within one period plus latency
    assign tick = mode_s ? pclk_rise : 1'b1;

    assign sel = ~cs_n_s;
    assign rd_req = sel & ~rd_n_s;
    assign wr_req = sel & ~wr_n_s & rd_n_s;
    assign accept = (state_q == hpp_pkg::HPP_D_IDLE) & tick & (rd_req | wr_req);
    assign alarm_hit = (addr_s == `HPP_ALARM_ADDR);

    // cycle sequencer
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= hpp_pkg::HPP_D_IDLE;
        end else if (!rst_n_s) begin
            state_q <= hpp_pkg::HPP_D_IDLE;
        end else begin
            unique case (state_q)
                hpp_pkg::HPP_D_IDLE: begin
                    if (accept) begin
                        state_q <= hpp_pkg::HPP_D_DONE;
                    end
                end
                hpp_pkg::HPP_D_DONE: begin
                    // a held strobe keeps the cycle closed, so one strobe is one access
                    if (!(rd_req | wr_req)) begin
                        state_q <= hpp_pkg::HPP_D_IDLE;
                    end
                end
            endcase
        end
    end

    assign bus.ready_n = (state_q != hpp_pkg::HPP_D_DONE);

    // read data capture
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= 8'h00;
        end else if (accept && rd_req) begin
            rdata_q <= alarm_hit ? status_q : mem_q[addr_s];
        end
    end

    assign bus.d_dev = rdata_q;
    // drivers on only for a selected read, never during reset
    assign bus.d_dev_oe = rd_req & rst_n_s;

    // register store; left without reset, contents are unknown until written
    always_ff @(posedge ref_clk_i) begin
        if (accept && wr_req && rst_n_s && !alarm_hit) begin
            mem_q[addr_s] <= d_s;
        end
    end

    // write report to the user side
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_stb_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_stb_q <= accept & wr_req & rst_n_s & ~alarm_hit;
            if (accept && wr_req) begin
                wr_addr_q <= addr_s;
                wr_data_q <= d_s;
            end
        end
    end

    assign wr_stb_o = wr_stb_q;
    assign wr_addr_o = wr_addr_q;
    assign wr_data_o = wr_data_q;

    // alarm change detection; a change in the clearing read's own cycle
    // stays set, so no event is lost
    always_comb begin
        status_d = status_q;
        if (accept && rd_req && alarm_hit) begin
            status_d = '0;
        end
        status_d = status_d | (alarm_i ^ alarm_q);
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            alarm_q <= '0;
            status_q <= '0;
            irq_n_q <= 1'b1;
        end else if (!rst_n_s) begin
            alarm_q <= alarm_i;
            status_q <= '0;
            irq_n_q <= 1'b1;
        end else begin
            alarm_q <= alarm_i;
            status_q <= status_d;
            irq_n_q <= ~(|status_d);
        end
    end

    assign bus.alarm_irq_n = irq_n_q;
    assign sync_mode_o = mode_s;
endmodule : hpp_dev

// ### hdl/hpp_host.sv
// local processor end of the host parallel register port
`timescale 1ns/1ps
`include "hpp_cfg.svh"
module hpp_host (
    input wire logic ref_clk_i, // 200 MHz core clock
    input wire logic resetn_i, // async reset, active low
    hpp_if.host bus, // pins to the device
    input wire logic sync_mode_i, // timing mode to strap, high is sync
    input wire logic dev_reset_i, // hold the device in reset while high
    input wire logic req_valid_i, // command request
    input wire logic req_write_i, // high write, low read
    input wire logic [7:0] req_addr_i, // register address
    input wire logic [7:0] req_wdata_i, // write byte
    output logic req_ready_o, // command taken when valid and ready
    output logic done_o, // one-cycle pulse, command finished
    output logic [7:0] rdata_o, // byte of the last read
    output logic irq_o // device interrupt, synchronised, high active
);
    logic [`HPP_HOST_SYNC_W-1:0] pins;
    logic [`HPP_HOST_SYNC_W-1:0] pins_s;
    logic rdy_n_s;
    logic irq_n_s;
    logic [7:0] d_s;

    hpp_pkg::hpp_host_state_t state_q;
    logic [`HPP_CNT_W-1:0] cnt_q;
    logic [`HPP_CNT_W-1:0] pw_min;
    logic [`HPP_CNT_W-1:0] div_q;
    logic pclk_q;
    logic mode_q;
    logic dev_rst_q;
    logic we_q;
    logic cs_n_q;
    logic rd_n_q;
    logic wr_n_q;
    logic oe_q;
    logic [7:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] rdata_q;
    logic done_q;

    assign pins = {bus.ready_n, bus.alarm_irq_n, bus.d};

    hpp_sync #(
        .W(`HPP_HOST_SYNC_W)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .d_i(pins),
        .q_o(pins_s)
    );

    assign {rdy_n_s, irq_n_s, d_s} = pins_s;

    // bus clock divider, free running
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= '0;
            pclk_q <= 1'b0;
        end else if (div_q == `HPP_CNT_W'(`HPP_PCLK_HALF_CYC - 1)) begin
            div_q <= '0;
            pclk_q <= ~pclk_q;
        end else begin
            div_q <= div_q + `HPP_CNT_W'(1);
        end
    end

    // straps
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_q <= 1'b0;
            dev_rst_q <= 1'b1;
        end else begin
            mode_q <= sync_mode_i;
            dev_rst_q <= dev_reset_i;
        end
    end

    assign pw_min = mode_q ? `HPP_CNT_W'(`HPP_PW_SYNC_CYC) : `HPP_CNT_W'(`HPP_PW_ASYNC_CYC);

    // command sequencer
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= hpp_pkg::HPP_H_IDLE;
            cnt_q <= '0;
            we_q <= 1'b0;
            cs_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            oe_q <= 1'b0;
            addr_q <= 8'h00;
            wdata_q <= 8'h00;
            rdata_q <= 8'h00;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                hpp_pkg::HPP_H_IDLE: begin
                    if (req_valid_i) begin
                        // address and write byte settle with chip select
                        addr_q <= req_addr_i;
                        wdata_q <= req_wdata_i;
                        we_q <= req_write_i;
                        oe_q <= req_write_i;
                        cs_n_q <= 1'b0;
                        state_q <= hpp_pkg::HPP_H_SETUP;
                    end
                end
                hpp_pkg::HPP_H_SETUP: begin
                    rd_n_q <= we_q;
                    wr_n_q <= ~we_q;
                    cnt_q <= '0;
                    state_q <= hpp_pkg::HPP_H_STROBE;
                end
                hpp_pkg::HPP_H_STROBE: begin
                    if (cnt_q != pw_min) begin
                        cnt_q <= cnt_q + `HPP_CNT_W'(1);
                    end
                    // synchronised data and ready arrive together
                    if (!rdy_n_s && cnt_q == pw_min) begin
                        rdata_q <= we_q ? rdata_q : d_s;
                        rd_n_q <= 1'b1;
                        wr_n_q <= 1'b1;
                        state_q <= hpp_pkg::HPP_H_HOLD;
                    end
                end
                hpp_pkg::HPP_H_HOLD: begin
                    if (rdy_n_s) begin
                        cs_n_q <= 1'b1;
                        oe_q <= 1'b0;
                        cnt_q <= '0;
                        state_q <= hpp_pkg::HPP_H_GAP;
                    end
                end
                hpp_pkg::HPP_H_GAP: begin
                    cnt_q <= cnt_q + `HPP_CNT_W'(1);
                    if (cnt_q == `HPP_CNT_W'(`HPP_GAP_CYC - 1)) begin
                        done_q <= 1'b1;
                        state_q <= hpp_pkg::HPP_H_IDLE;
                    end
                end
                default: begin
                    state_q <= hpp_pkg::HPP_H_IDLE;
                end
            endcase
        end
    end

    assign bus.host_bus_clock = pclk_q;
    assign bus.bus_timing_select = mode_q;
    assign bus.dev_reset_n = ~dev_rst_q;
    assign bus.chip_select_n = cs_n_q;
    assign bus.read_strobe_n = rd_n_q;
    assign bus.store_strobe_n = wr_n_q;
    assign bus.addr = addr_q;
    assign bus.d_host = wdata_q;
    assign bus.d_host_oe = oe_q;

    assign req_ready_o = (state_q == hpp_pkg::HPP_H_IDLE);
    assign done_o = done_q;
    assign rdata_o = rdata_q;
    assign irq_o = ~irq_n_s;
endmodule : hpp_host

// ### hdl/hpp_if.sv
// pins between the local processor and the register port
`timescale 1ns/1ps
`include "hpp_cfg.svh"
interface hpp_if;
    logic bus_timing_select;
    logic host_bus_clock;
    logic dev_reset_n;
    logic chip_select_n;
    logic read_strobe_n;
    logic store_strobe_n;
    logic [7:0] addr;
    logic [7:0] d_host;
    logic d_host_oe;
    logic [7:0] d_dev;
    logic d_dev_oe;
    logic [7:0] d;
    logic ready_n;
    logic alarm_irq_n;

    // undriven data bus rests on its pull-ups
    assign d = d_dev_oe ? d_dev : (d_host_oe ? d_host : `HPP_BUS_IDLE);

    modport dev (
        input bus_timing_select, host_bus_clock, dev_reset_n, chip_select_n,
        input read_strobe_n, store_strobe_n, addr, d,
        output d_dev, d_dev_oe, ready_n, alarm_irq_n
    );
    modport host (
        output bus_timing_select, host_bus_clock, dev_reset_n, chip_select_n,
        output read_strobe_n, store_strobe_n, addr, d_host, d_host_oe,
        input d, ready_n, alarm_irq_n
    );
endinterface : hpp_if

// ### hdl/hpp_pkg.sv
// state types of the host parallel register port
package hpp_pkg;
    typedef enum logic {
        HPP_D_IDLE,
        HPP_D_DONE
    } hpp_dev_state_t;

    typedef enum logic [2:0] {
        HPP_H_IDLE,
        HPP_H_SETUP,
        HPP_H_STROBE,
        HPP_H_HOLD,
        HPP_H_GAP
    } hpp_host_state_t;
endpackage : hpp_pkg

// ### hdl/hpp_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module hpp_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i, // core clock
    input wire logic resetn_i, // async reset, active low
    input wire logic [W-1:0] d_i, // pin levels
    output logic [W-1:0] q_o // synchronised levels
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // resets high: all but the mode, bus clock and address pins it carries are idle high
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule : hpp_sync
